// ### tli_params.svh
`ifndef TLI_PARAMS_SVH
`define TLI_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TLI_OFF_PRIMARY_EN   8'h00
`define TLI_OFF_EXT_EN_TWO   8'h04
`define TLI_OFF_PRIORITY     8'h08
`define TLI_OFF_PENDING      8'h0C
`define TLI_OFF_TIMER_CTRL   8'h10
`define TLI_OFF_SOFT_FLAGS   8'h14
`define TLI_OFF_EVT_STATUS   8'h18
`define TLI_OFF_EVT_MASK     8'h1C
`define TLI_OFF_CORE_STATE   8'h20

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TLI_BIT_GLOBAL_EN    7
`define TLI_PRIMARY_SRCS     7
`define TLI_BIT_A_TRIG       0
`define TLI_BIT_A_PEND       1
`define TLI_BIT_B_TRIG       2
`define TLI_BIT_B_PEND       3
`define TLI_EVT_CALL         0
`define TLI_EVT_RETURN       1
`define TLI_EVT_PREEMPT      2

// ---------------------------------------------------------------
// Source map, vectors and reset values
// ---------------------------------------------------------------
`define TLI_SRC_EXT_A        0
`define TLI_SRC_EXT_B        1
`define TLI_SRC_SOFT0        11
`define TLI_NUM_SOFT         4
`define TLI_NUM_PERIPH       9
`define TLI_VEC_BASE         16'h0003
`define TLI_RST_WORD         32'h0000_0000

`endif

// ### tli_pkg.sv
package tli_pkg;

   // Vector call handed to the instruction sequencer
   typedef struct packed {
      logic [15:0] addr;
      logic [4:0]  src;
      logic        high;
   } tli_call_t;

   // Latched bus address phase
   typedef struct packed {
      logic       write;
      logic [7:0] addr;
   } tli_dphase_t;

   typedef enum logic [1:0] {
      TLI_RUN  = 2'b00,
      TLI_HOLD = 2'b01
   } tli_state_t;

endpackage

// ### tli_handler.sv
`timescale 1ns/10ps
`include "tli_params.svh"
// Behaviour
// - Up to 22 sources, each placed at high or low priority.
// - A source event sets its pending flag regardless of its enable.
// - Enabled pending source requests; call its vector after current instruction.
// - Return resumes the interrupted flow; the active level is released.
// - Pending flags of disabled sources are ignored, no vectoring.
// - Every source has its own enable bit in the enable registers.
// - Global enable at primary enable bit 7 gates all individual enables.
// - Some flags clear on vectoring; most stay until software clears them.
// - Flag still set after return re-enters after one more instruction.
// - Sixteen sources (2..10, 15..21) serve on-chip peripherals with own vector and order.
// - Software writing one to a pending flag sets it, but a vectoring clear in that cycle wins; external flags in level mode ignore it.
// - External inputs active low; trigger select at timer control bits 0, 2.
// - External pending flags sit at timer control bits 1 and 3.
// - Edge mode clears the external pending flag on vectoring.
// - Level mode pending flag follows the pin, no latching.
// - Four software flags vector to own address; only software clears them.
module tli_handler
   import tli_pkg::*;
#(
   parameter int          NS       = 22,
   parameter logic [21:0] AUTO_CLR = 22'h00_0004
) (
   // Clock, reset, enable
   input  wire logic          sys_clk_in,
   input  wire logic          resetn_in,
   input  wire logic          ce_in,
   // AHB-Lite slave
   input  wire logic          hsel_in,
   input  wire logic [7:0]    haddr_in,
   input  wire logic [1:0]    htrans_in,
   input  wire logic          hwrite_in,
   input  wire logic [2:0]    hsize_in,
   input  wire logic [31:0]   hwdata_in,
   input  wire logic          hready_in,
   output logic [31:0]        hrdata_out,
   output logic               hreadyout_out,
   output logic               hresp_out,
   // Sources
   input  wire logic [NS-1:0] periph_evt_in,
   input  wire logic          ext_a_irq_pin_n_in,
   input  wire logic          ext_b_irq_pin_n_in,
   // Instruction sequencer
   input  wire logic          instr_done_in,
   input  wire logic          reti_done_in,
   output logic               irq_req_out,
   output logic               call_req_out,
   output tli_call_t          call_out,
   output logic [1:0]         active_lvl_out,
   // Host interrupt
   output logic               irq_out
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [NS-1:0] pend, enable, prio, hw_set, hw_clr, sw_en, sw_val, elig, hi_req, lo_req;
   logic [NS-1:0] is_soft, is_periph;
   logic          global_irq_mask;
   logic [1:0]    trig_sel, pin_q, ext_edge, ext_pin_n;
   logic          act_hi, act_lo, take_hi, take_lo, req_any, fire;
   logic [4:0]    sel_idx;
   logic [2:0]    evt_status, evt_mask, evt_now, next_status;
   tli_state_t    state;
   tli_dphase_t   dph;
   logic          dph_valid, wr_now;
   logic [31:0]   rd_word;

   assign ext_pin_n = {ext_b_irq_pin_n_in, ext_a_irq_pin_n_in};
   assign wr_now    = dph_valid && dph.write;

   function automatic logic [4:0] first_one(input logic [NS-1:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         dph_valid     <= 1'b0;
         dph           <= '0;
         hrdata_out    <= `TLI_RST_WORD;
         hreadyout_out <= 1'b0;
         hresp_out     <= 1'b0;
      end else if (ce_in) begin
         // Zero wait states: read data is captured in the address phase
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
         dph_valid     <= hsel_in && htrans_in[1] && hready_in;
         dph.write     <= hwrite_in;
         dph.addr      <= haddr_in;
         if (hsel_in && htrans_in[1] && hready_in && !hwrite_in) begin
            hrdata_out <= rd_word;
         end
      end
   end

   always_comb begin
      rd_word = `TLI_RST_WORD;
      unique case (haddr_in)
         `TLI_OFF_PRIMARY_EN: begin
            rd_word[`TLI_BIT_GLOBAL_EN] = global_irq_mask;
            rd_word[`TLI_PRIMARY_SRCS-1:0] = enable[`TLI_PRIMARY_SRCS-1:0];
         end
         `TLI_OFF_EXT_EN_TWO: rd_word[NS-1-`TLI_PRIMARY_SRCS:0] = enable[NS-1:`TLI_PRIMARY_SRCS];
         `TLI_OFF_PRIORITY:   rd_word[NS-1:0] = prio;
         `TLI_OFF_PENDING:    rd_word[NS-1:0] = pend;
         `TLI_OFF_TIMER_CTRL: begin
            rd_word[`TLI_BIT_A_TRIG] = trig_sel[0];
            rd_word[`TLI_BIT_A_PEND] = pend[`TLI_SRC_EXT_A];
            rd_word[`TLI_BIT_B_TRIG] = trig_sel[1];
            rd_word[`TLI_BIT_B_PEND] = pend[`TLI_SRC_EXT_B];
         end
         `TLI_OFF_SOFT_FLAGS:
            rd_word[`TLI_NUM_SOFT-1:0] = pend[`TLI_SRC_SOFT0 +: `TLI_NUM_SOFT];
         `TLI_OFF_EVT_STATUS: rd_word[2:0] = evt_status;
         `TLI_OFF_EVT_MASK:   rd_word[2:0] = evt_mask;
         `TLI_OFF_CORE_STATE: rd_word[4:0] = {state == TLI_HOLD, act_lo, act_hi, trig_sel};
         default: rd_word = `TLI_RST_WORD;
      endcase
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         global_irq_mask <= 1'b0;
         enable          <= '0;
         prio            <= '0;
         trig_sel        <= 2'b00;
         evt_mask        <= 3'h0;
      end else if (ce_in && wr_now) begin
         unique case (dph.addr)
            `TLI_OFF_PRIMARY_EN: begin
               global_irq_mask <= hwdata_in[`TLI_BIT_GLOBAL_EN];
               enable[`TLI_PRIMARY_SRCS-1:0] <= hwdata_in[`TLI_PRIMARY_SRCS-1:0];
            end
            `TLI_OFF_EXT_EN_TWO:
               enable[NS-1:`TLI_PRIMARY_SRCS] <= hwdata_in[NS-1-`TLI_PRIMARY_SRCS:0];
            `TLI_OFF_PRIORITY: prio <= hwdata_in[NS-1:0];
            `TLI_OFF_TIMER_CTRL: begin
               trig_sel <= {hwdata_in[`TLI_BIT_B_TRIG], hwdata_in[`TLI_BIT_A_TRIG]};
            end
            `TLI_OFF_EVT_MASK: evt_mask <= hwdata_in[2:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pending flags
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         pin_q <= 2'b11;
      end else if (ce_in) begin
         pin_q <= ext_pin_n;
      end
   end

   // Falling edge on an active-low pin
   assign ext_edge = pin_q & ~ext_pin_n & trig_sel;

   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_src
         // Clamped indices keep branches that never apply inside their vectors
         localparam int SOFT_BIT  = (g >= `TLI_SRC_SOFT0) ? g - `TLI_SRC_SOFT0 : 0;
         localparam int TIMER_BIT = (g < 2) ? 2 * g + 1 : 0;
         localparam int PIN_BIT   = (g < 2) ? g : 0;
         assign is_soft[g]   = (g >= `TLI_SRC_SOFT0) && (g < `TLI_SRC_SOFT0 + `TLI_NUM_SOFT);
         // Sources 2..10 and 15..21 are peripherals; the four soft flags 11..14 sit between them
         assign is_periph[g] = (g > `TLI_SRC_EXT_B) && !is_soft[g];
         always_comb begin
            sw_en[g]  = 1'b0;
            sw_val[g] = 1'b0;
            if (wr_now && dph.addr == `TLI_OFF_PENDING) begin
               sw_en[g]  = 1'b1;
               sw_val[g] = hwdata_in[g];
            end else if (wr_now && dph.addr == `TLI_OFF_SOFT_FLAGS && is_soft[g]) begin
               sw_en[g]  = 1'b1;
               sw_val[g] = hwdata_in[SOFT_BIT];
            end else if (wr_now && dph.addr == `TLI_OFF_TIMER_CTRL && g < 2) begin
               sw_en[g]  = 1'b1;
               sw_val[g] = hwdata_in[TIMER_BIT];
            end
         end
         if (g < 2) begin : g_ext
            assign hw_set[g] = ext_edge[g];
            assign hw_clr[g] = fire && sel_idx == 5'(g) && trig_sel[g];
         end else begin : g_int
            // Soft flags have no hardware setter and no hardware clear
            assign hw_set[g] = periph_evt_in[g] && is_periph[g];
            assign hw_clr[g] = fire && sel_idx == 5'(g) && AUTO_CLR[g] && !is_soft[g];
         end
         always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
               pend[g] <= 1'b0;
            end else if (ce_in) begin
               if (g < 2 && !trig_sel[PIN_BIT]) begin
                  // The source must hold the pin until called and drop it before return
                  pend[g] <= !ext_pin_n[PIN_BIT];
               end else begin
                  // A hardware set wins over any clear in the same cycle
                  pend[g] <= ((sw_en[g] ? sw_val[g] : pend[g]) && !hw_clr[g]) || hw_set[g];
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Arbitration and vectoring
   // ------------------------------------------------------------
   assign elig    = pend & enable & {NS{global_irq_mask}};
   assign hi_req  = elig & prio;
   assign lo_req  = elig & ~prio;
   assign take_hi = (|hi_req) && !act_hi;
   assign take_lo = (|lo_req) && !act_hi && !act_lo;
   assign req_any = take_hi || take_lo;
   // Lowest index wins within a level
   assign sel_idx = first_one(take_hi ? hi_req : lo_req);
   // The first instruction completed after a return may already vector
   assign fire    = ce_in && instr_done_in && !reti_done_in && req_any;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state <= TLI_RUN;
      end else if (ce_in) begin
         unique case (state)
            TLI_RUN:  if (reti_done_in) state <= TLI_HOLD;
            TLI_HOLD: if (instr_done_in && !reti_done_in) state <= TLI_RUN;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         act_hi <= 1'b0;
         act_lo <= 1'b0;
      end else if (ce_in) begin
         if (fire) begin
            if (take_hi) act_hi <= 1'b1;
            else act_lo <= 1'b1;
         end else if (reti_done_in) begin
            // Return closes the innermost routine
            if (act_hi) act_hi <= 1'b0;
            else act_lo <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         irq_req_out    <= 1'b0;
         call_req_out   <= 1'b0;
         call_out       <= '0;
         active_lvl_out <= 2'b00;
      end else if (ce_in) begin
         irq_req_out    <= req_any;
         call_req_out   <= fire;
         active_lvl_out <= {act_hi, act_lo};
         if (fire) begin
            call_out.addr <= `TLI_VEC_BASE + {8'h00, sel_idx, 3'b000};
            call_out.src  <= sel_idx;
            call_out.high <= take_hi;
         end
      end
   end

   // ------------------------------------------------------------
   // Host interrupt
   // ------------------------------------------------------------
   assign evt_now = {fire && take_hi && act_lo, ce_in && reti_done_in, fire};

   always_comb begin
      next_status = evt_status;
      if (wr_now && dph.addr == `TLI_OFF_EVT_STATUS) begin
         next_status = evt_status & ~hwdata_in[2:0];
      end
      next_status = next_status | evt_now;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         evt_status <= 3'h0;
         irq_out    <= 1'b0;
      end else if (ce_in) begin
         evt_status <= next_status;
         irq_out    <= |(next_status & evt_mask);
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_hold_step;
      state == TLI_HOLD && ce_in;
   endsequence
   sequence s_next_ready;
      ce_in && instr_done_in && !reti_done_in && req_any;
   endsequence

   a_call_enabled: assert property (
      call_req_out |-> ($past(elig) & (22'(1) << call_out.src)) != '0)
      else $error("call issued for a source not enabled");
   a_call_after_instr: assert property (
      call_req_out |-> $past(instr_done_in) && !$past(reti_done_in))
      else $error("call issued without instruction completion");
   a_level_follow: assert property (
      ce_in && !trig_sel[0] |=> pend[0] == !$past(ext_a_irq_pin_n_in))
      else $error("level-mode flag does not follow pin");
   a_edge_clear: assert property (
      fire && sel_idx == 5'h00 && trig_sel[0] && !ext_edge[0] && !sw_en[0] |=> !pend[0])
      else $error("edge-mode flag not cleared on vectoring");
   a_soft_no_hw: assert property (
      ce_in && !sw_en[`TLI_SRC_SOFT0] |=> !$rose(pend[`TLI_SRC_SOFT0]) && !$fell(pend[`TLI_SRC_SOFT0]))
      else $error("soft flag changed without a software write");
   a_set_wins: assert property (
      ce_in && periph_evt_in[2] |=> pend[2])
      else $error("peripheral event lost");
   a_sw_set: assert property (
      ce_in && sw_en[5] && sw_val[5] |=> pend[5])
      else $error("software write of one not taken");
   a_reentry_step: assert property (
      s_hold_step ##0 s_next_ready |=> call_req_out)
      else $error("no re-entry after one instruction");
   a_hold_blocks: assert property (
      state == TLI_HOLD && !instr_done_in |=> !call_req_out)
      else $error("call taken before one instruction after return");
   a_hi_preempt: assert property (
      ce_in && instr_done_in && !reti_done_in && state == TLI_RUN && (|hi_req) && !act_hi
      |=> call_req_out && call_out.high)
      else $error("high request did not preempt");
   a_same_level_wait: assert property (
      act_hi && !reti_done_in |=> !call_req_out)
      else $error("request entered during high routine");

endmodule

// ### tli_seq_model.sv
`timescale 1ns/10ps
module tli_seq_model
   import tli_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       resetn_in,
   // Bench commands
   input  wire logic [3:0] gap_in,
   input  wire logic       reti_req_in,
   input  wire logic [1:0] pin_fire_in,
   // Handler side
   input  wire logic       call_req_in,
   input  wire tli_call_t  call_in,
   output logic            instr_done_out = 1'h0,
   output logic            reti_done_out  = 1'h0,
   output logic [1:0]      pin_n_out      = 2'h3
);
   logic [3:0] cnt       = 4'h0;
   logic       reti_pend = 1'h0;

   // ------------------------------------------------------------
   // Sequencer: one instruction ends every gap_in + 1 cycles
   // ------------------------------------------------------------
   always @(posedge sys_clk_in) begin
      instr_done_out <= 1'h0;
      reti_done_out <= 1'h0;
      if (!resetn_in) begin
         cnt <= 4'h0;
         reti_pend <= 1'h0;
      end else begin
         if (reti_req_in) begin
            reti_pend <= 1'h1;
         end
         if (cnt >= gap_in) begin
            cnt <= 4'h0;
            if (reti_pend) begin
               // Return takes the slot of an ordinary instruction
               reti_done_out <= 1'h1;
               reti_pend <= 1'h0;
            end else begin
               instr_done_out <= 1'h1;
            end
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // External sources: pin held low until its vector is taken
   // ------------------------------------------------------------
   always @(posedge sys_clk_in) begin
      for (int p = 0; p < 2; p++) begin
         if (!resetn_in) begin
            pin_n_out[p] <= 1'h1;
         end else if (pin_fire_in[p]) begin
            pin_n_out[p] <= 1'h0;
         end else if (call_req_in && call_in.src == 5'(p)) begin
            pin_n_out[p] <= 1'h1;
         end
      end
   end
endmodule

// ### tb.sv
`timescale 1ns/10ps
`include "tli_params.svh"
`define CHK(n, e, g) begin \
   checks++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("ERROR %s expected %0h seen %0h", n, e, g); \
   end \
end
module tb
   import tli_pkg::*;
;
   logic        clk = 1'h0;
   logic        rstn, hsel, hwrite, reti_req, hready, hresp, idone, rdone, ireq, creq, irq;
   logic        rd_ph = 1'h0;
   logic [7:0]  haddr;
   logic [1:0]  htrans, fire, lvl, pin_n;
   logic [3:0]  gap;
   logic [21:0] periph, prio;
   logic [31:0] hwdata, hrdata, e_rd;
   logic [31:0] seed = 32'h6C03;
   logic [31:0] rd_q[$];
   tli_call_t   call, e_call;
   tli_call_t   call_q[$];
   int          errors = 0;
   int          checks = 0;

   always #2.5 clk = ~clk;

   tli_handler i_dut (
      .sys_clk_in(clk), .resetn_in(rstn), .ce_in(1'h1), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .periph_evt_in(periph),
      .ext_a_irq_pin_n_in(pin_n[0]), .ext_b_irq_pin_n_in(pin_n[1]),
      .instr_done_in(idone), .reti_done_in(rdone), .irq_req_out(ireq),
      .call_req_out(creq), .call_out(call), .active_lvl_out(lvl), .irq_out(irq));

   tli_seq_model i_seq (
      .sys_clk_in(clk), .resetn_in(rstn), .gap_in(gap), .reti_req_in(reti_req),
      .pin_fire_in(fire), .call_req_in(creq), .call_in(call),
      .instr_done_out(idone), .reti_done_out(rdone), .pin_n_out(pin_n));

   // ------------------------------------------------------------
   // Bench tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic timeout();
      errors++;
      print_verdict();
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (hready !== 1'h1 && n < 50);
         if (n >= 50) timeout();
         if (p == 0) begin
            htrans <= 2'h0;
            hwdata <= d;
         end
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'h0, a, 32'h0);
   endtask

   task automatic wait_lvl(input logic [1:0] l);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (lvl !== l && n < 300);
      if (n >= 300) timeout();
   endtask

   task automatic wait_q();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (call_q.size() != 0 && n < 300);
      if (n >= 300) timeout();
   endtask

   task automatic exp_call(input int s, input logic h);
      call_q.push_back(tli_call_t'{addr: `TLI_VEC_BASE + 16'(s * 8), src: 5'(s), high: h});
   endtask

   // Only source s enabled; g carries the global enable
   task automatic en(input int s, input logic [7:0] g);
      wr(`TLI_OFF_PRIMARY_EN, 32'(g) | ((s < 7) ? 32'h1 << s : 32'h0));
      wr(`TLI_OFF_EXT_EN_TWO, (s >= 7) ? 32'h1 << (s - 7) : 32'h0);
   endtask

   task automatic pulse(input logic [21:0] m);
      periph <= m;
      @(posedge clk);
      periph <= 22'h0;
   endtask

   task automatic ret();
      reti_req <= 1'h1;
      @(posedge clk);
      reti_req <= 1'h0;
   endtask

   // ------------------------------------------------------------
   // Result monitor: oldest note against what appears
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rd_ph && hready) begin
         e_rd = rd_q.pop_front();
         `CHK("hrdata", e_rd, hrdata)
         `CHK("hresp", 1'h0, hresp)
      end
      if (hready) rd_ph <= hsel && htrans[1] && !hwrite;
      if (creq === 1'h1) begin
         e_call = (call_q.size() != 0) ? call_q.pop_front() : 22'h0;
         `CHK("call", e_call, call)
      end
   end

   initial begin
      repeat (100000) @(posedge clk);
      timeout();
   end

   initial begin
      int          s;
      logic [31:0] t;
      {rstn, hsel, hwrite, reti_req, fire, htrans, haddr} = '0;
      {hwdata, periph, gap} = '0;
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      repeat (2) @(posedge clk);
      for (int a = 0; a < 44; a += 4) rd(8'(a), 32'h0);
      wr(8'h24, 32'hFFFF_FFFF);
      rd(8'h24, 32'h0);
      prio = 22'(rnd());
      wr(`TLI_OFF_PRIORITY, 32'(prio));
      rd(`TLI_OFF_PRIORITY, 32'(prio));
      // Flag collects while masked; global enable releases it
      en(3, 8'h00);
      pulse(22'h8);
      rd(`TLI_OFF_PENDING, 32'h8);
      repeat (20) @(posedge clk);
      `CHK("irq_req", 1'h0, ireq)
      exp_call(3, prio[3]);
      en(3, 8'h80);
      wait_q();
      exp_call(3, prio[3]);
      ret();
      wait_q();
      wr(`TLI_OFF_PENDING, 32'h0);
      ret();
      wait_lvl(2'h0);
      for (s = 2; s < 22; s++) if (s < 11 || s > 14) begin
         gap <= 4'(rnd() % 6);
         en(s, 8'h80);
         exp_call(s, prio[s]);
         if (rnd() % 2 == 0) pulse(22'h1 << s);
         else wr(`TLI_OFF_PENDING, 32'h1 << s);
         wait_q();
         rd(`TLI_OFF_PENDING, (s == 2) ? 32'h0 : 32'h1 << s);
         wr(`TLI_OFF_PENDING, 32'h0);
         ret();
         wait_lvl(2'h0);
      end
      for (int k = 0; k < 4; k++) begin
         en(11 + k, 8'h80);
         exp_call(11 + k, prio[11 + k]);
         wr(`TLI_OFF_SOFT_FLAGS, 32'h1 << k);
         repeat (2) @(posedge clk);
         `CHK("irq_req", 1'h1, ireq)
         wait_q();
         rd(`TLI_OFF_SOFT_FLAGS, 32'h1 << k);
         wr(`TLI_OFF_SOFT_FLAGS, 32'h0);
         ret();
         wait_lvl(2'h0);
      end
      for (int p = 0; p < 2; p++) for (int e = 0; e < 2; e++) begin
         t = 32'(e) << (2 * p);
         en(30, 8'h80);
         wr(`TLI_OFF_TIMER_CTRL, t);
         fire <= 2'(1 << p);
         @(posedge clk);
         fire <= 2'h0;
         repeat (4) @(posedge clk);
         rd(`TLI_OFF_TIMER_CTRL, t | (32'h2 << (2 * p)));
         exp_call(p, prio[p]);
         en(p, 8'h80);
         wait_q();
         repeat (4) @(posedge clk);
         rd(`TLI_OFF_TIMER_CTRL, t);
         ret();
         wait_lvl(2'h0);
      end
      // High source preempts a low routine; a low one waits
      wr(`TLI_OFF_EVT_STATUS, 32'h7);
      wr(`TLI_OFF_PRIORITY, 32'h8);
      wr(`TLI_OFF_PRIMARY_EN, 32'hB8);
      wr(`TLI_OFF_EXT_EN_TWO, 32'h0);
      exp_call(4, 1'h0);
      pulse(22'h10);
      wait_lvl(2'h1);
      wr(`TLI_OFF_PENDING, 32'h0);
      exp_call(3, 1'h1);
      pulse(22'h28);
      wait_lvl(2'h3);
      wr(`TLI_OFF_PENDING, 32'h20);
      ret();
      wait_lvl(2'h1);
      repeat (20) @(posedge clk);
      exp_call(5, 1'h0);
      ret();
      wait_q();
      wr(`TLI_OFF_PENDING, 32'h0);
      ret();
      wait_lvl(2'h0);
      rd(`TLI_OFF_EVT_STATUS, 32'h7);
      `CHK("irq", 1'h0, irq)
      wr(`TLI_OFF_EVT_MASK, 32'h4);
      repeat (3) @(posedge clk);
      `CHK("irq", 1'h1, irq)
      wr(`TLI_OFF_EVT_STATUS, 32'h4);
      repeat (3) @(posedge clk);
      `CHK("irq", 1'h0, irq)
      rd(`TLI_OFF_EVT_STATUS, 32'h3);
      `CHK("calls left", 0, call_q.size())
      print_verdict();
   end
endmodule
